// >>> rtl/bwc_window_regs.sv
// Notes on behaviour
// - Prefetch limit low nibble reads one, read-only.
// - Prefetch limit bits 31:20 writable, reset zero.
// - Prefetch window top low twenty bits ones.
// - Prefetch bottom upper 32 bits writable register.
// - Prefetch top upper 32 bits writable register.
// - Full 64-bit prefetch window decides memory forwarding.
// - I/O bottom upper 16 bits writable, reset zero.
// - I/O top upper 16 bits, same dword.
// - 32-bit I/O window decides I/O forwarding.
// - Capability pointer read-only, default hex 40.
// - Interrupt line stores writes, no effect.
// - Interrupt pin zero upstream, one downstream.
// - Downstream hot-plug events use first virtual wire.
// - Prefetch window bottom low twenty bits zero.
module bwc_window_regs #(
    parameter bit IS_DOWNSTREAM = 1'b1,
    parameter int IO_LOW_BITS = 16
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire bwc_pkg::bwc_cfg_wr_t cfg_wr,
    input wire logic cfg_rd_valid,
    input wire logic [7:0] cfg_rd_offset,
    output logic [31:0] cfg_rd_data,
    input wire bwc_pkg::bwc_preload_t preload,
    input wire logic [63:0] mem_addr,
    input wire logic [31:0] io_addr,
    input wire logic [11:0] io_base_low,
    input wire logic [11:0] io_limit_low,
    input wire logic hotplug_event,
    output logic mem_fwd,
    output logic io_fwd,
    output logic hotplug_irq
);
    if (IO_LOW_BITS != 16) begin : g_bad_io_width
        $error("IO_LOW_BITS must be 16");
    end

    bwc_pkg::bwc_state_t state;
    bwc_pkg::bwc_state_t next_state;

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic [31:0] read_word(input bwc_pkg::bwc_state_t s,
                                              input logic [7:0] ofs);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (ofs)
            bwc_pkg::OFS_PREF_DW: begin
                r[bwc_pkg::PREF_BOT_LSB +: 4] = bwc_pkg::PREF_64BIT_CODE;
                r[bwc_pkg::PREF_BOT_LSB +: 12] = s.pref_bot;
                r[bwc_pkg::PREF_CAP_LSB +: 4] = bwc_pkg::PREF_64BIT_CODE;
                r[bwc_pkg::PREF_TOP_LSB +: 12] = s.pref_top;
                r[3:0] = bwc_pkg::PREF_64BIT_CODE;
            end
            bwc_pkg::OFS_PREF_BOT_HI: r = s.pref_bot_hi;
            bwc_pkg::OFS_PREF_TOP_HI: r = s.pref_top_hi;
            bwc_pkg::OFS_IO_HI: begin
                r[15:0] = s.io_bot_hi;
                r[bwc_pkg::IO_TOP_LSB +: 16] = s.io_top_hi;
            end
            bwc_pkg::OFS_CAP: r[7:0] = s.cap_ptr;
            bwc_pkg::OFS_IRQ: begin
                r[7:0] = s.irq_line;
                r[bwc_pkg::IRQ_PIN_LSB +: 8] = s.irq_pin;
            end
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    // Writes to one dword: read-only fields are simply not stored.
    function automatic bwc_pkg::bwc_state_t apply_write(
            input bwc_pkg::bwc_state_t s, input logic [7:0] ofs,
            input logic [31:0] wd, input logic [3:0] be, input logic pre);
        bwc_pkg::bwc_state_t n;
        logic [31:0] m;
        n = s;
        m = merge_be(read_word(s, ofs), wd, be);
        case (ofs)
            bwc_pkg::OFS_PREF_DW: begin
                n.pref_bot = m[bwc_pkg::PREF_BOT_LSB +: 12];
                n.pref_top = m[bwc_pkg::PREF_TOP_LSB +: 12];
            end
            bwc_pkg::OFS_PREF_BOT_HI: n.pref_bot_hi = m;
            bwc_pkg::OFS_PREF_TOP_HI: n.pref_top_hi = m;
            bwc_pkg::OFS_IO_HI: begin
                n.io_bot_hi = m[15:0];
                n.io_top_hi = m[bwc_pkg::IO_TOP_LSB +: 16];
            end
            bwc_pkg::OFS_CAP: begin
                if (pre) begin
                    n.cap_ptr = m[7:0];
                end
            end
            bwc_pkg::OFS_IRQ: begin
                n.irq_line = m[7:0];
                if (pre) begin
                    n.irq_pin = m[bwc_pkg::IRQ_PIN_LSB +: 8];
                end
            end
            default: n = s;
        endcase
        return n;
    endfunction

    // An inverted window must never match, so the order test comes first.
    function automatic logic window_hit(input logic [63:0] lo,
                                        input logic [63:0] hi,
                                        input logic [63:0] addr);
        return (lo <= hi) && (addr >= lo) && (addr <= hi);
    endfunction

    logic [63:0] pref_lo_addr;
    logic [63:0] pref_hi_addr;
    logic [31:0] io_lo_addr;
    logic [31:0] io_hi_addr;

    always_comb begin
        pref_lo_addr = {state.pref_bot_hi, state.pref_bot,
                        bwc_pkg::LOW20_ZERO};
        pref_hi_addr = {state.pref_top_hi, state.pref_top,
                        bwc_pkg::LOW20_ONES};
        io_lo_addr = {state.io_bot_hi, io_base_low[11:8], 12'h000};
        io_hi_addr = {state.io_top_hi, io_limit_low[11:8], 12'hFFF};
    end

    always_comb begin
        next_state = state;
        // Preload goes first so a same-cycle software write takes effect.
        if (preload.valid) begin
            next_state = apply_write(next_state, preload.offset,
                                     preload.data, 4'hF, 1'b1);
        end
        if (cfg_wr.valid) begin
            next_state = apply_write(next_state, cfg_wr.offset,
                                     cfg_wr.data, cfg_wr.byte_en, 1'b0);
        end
        next_state.rdata = cfg_rd_valid ?
                           read_word(state, cfg_rd_offset) : state.rdata;
        next_state.hotplug_irq = IS_DOWNSTREAM && hotplug_event;
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state.pref_bot <= bwc_pkg::RST_PREF_12;
            state.pref_top <= bwc_pkg::RST_PREF_12;
            state.pref_bot_hi <= bwc_pkg::RST_HI32;
            state.pref_top_hi <= bwc_pkg::RST_HI32;
            state.io_bot_hi <= bwc_pkg::RST_IO16;
            state.io_top_hi <= bwc_pkg::RST_IO16;
            state.cap_ptr <= bwc_pkg::RST_CAP_PTR;
            state.irq_line <= bwc_pkg::RST_IRQ_LINE;
            state.irq_pin <= IS_DOWNSTREAM ? bwc_pkg::IRQ_PIN_DOWN
                                           : bwc_pkg::IRQ_PIN_UP;
            state.rdata <= 32'h0000_0000;
            state.hotplug_irq <= 1'b0;
        end else begin
            state <= next_state;
        end
    end

    // Compare is combinational so forwarding needs no extra pipeline stage.
    assign mem_fwd = window_hit(pref_lo_addr, pref_hi_addr, mem_addr);
    assign io_fwd = window_hit({32'h0000_0000, io_lo_addr},
                               {32'h0000_0000, io_hi_addr},
                               {32'h0000_0000, io_addr});
    assign cfg_rd_data = state.rdata;
    assign hotplug_irq = state.hotplug_irq;

    // Checks watch only what this block drives; inputs belong to the bench.
    AST_CAP_NIBBLE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_PREF_DW
        |=> cfg_rd_data[19:16] == 4'h1)
        else $error("prefetch limit low nibble not one");
    AST_TOP_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.pref_top == 12'h000)
        else $error("prefetch top not reset");
    AST_TOP_WR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_wr.valid && cfg_wr.offset == bwc_pkg::OFS_PREF_DW &&
        cfg_wr.byte_en[3:2] == 2'b11 && !preload.valid
        |=> state.pref_top == $past(cfg_wr.data[31:20]))
        else $error("prefetch top not written");
    AST_TOP_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_PREF_DW
        |=> cfg_rd_data[31:20] == $past(state.pref_top))
        else $error("prefetch top read back wrong");
    AST_TOP_ONES: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_addr == {state.pref_top_hi, state.pref_top, 20'hFFFFF} &&
        pref_lo_addr <= pref_hi_addr |-> mem_fwd)
        else $error("window top not inclusive");
    AST_TOP_EDGE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        {state.pref_top_hi, state.pref_top} != 44'hFFF_FFFF_FFFF &&
        mem_addr == {state.pref_top_hi, state.pref_top, 20'hFFFFF} + 64'h1
        |-> !mem_fwd)
        else $error("forwarded past window top");
    AST_HI_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.pref_bot_hi == 32'h0000_0000 &&
                     state.pref_top_hi == 32'h0000_0000)
        else $error("prefetch upper halves not reset");
    AST_BOT_HI_WR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_wr.valid && cfg_wr.offset == bwc_pkg::OFS_PREF_BOT_HI &&
        cfg_wr.byte_en == 4'hF && !preload.valid
        |=> state.pref_bot_hi == $past(cfg_wr.data))
        else $error("prefetch bottom high not written");
    AST_BOT_HI_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_PREF_BOT_HI
        |=> cfg_rd_data == $past(state.pref_bot_hi))
        else $error("prefetch bottom high read back wrong");
    AST_TOP_HI_WR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_wr.valid && cfg_wr.offset == bwc_pkg::OFS_PREF_TOP_HI &&
        cfg_wr.byte_en == 4'hF && !preload.valid
        |=> state.pref_top_hi == $past(cfg_wr.data))
        else $error("prefetch top high not written");
    AST_TOP_HI_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_PREF_TOP_HI
        |=> cfg_rd_data == $past(state.pref_top_hi))
        else $error("prefetch top high read back wrong");
    AST_MEM_BELOW: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_addr < pref_lo_addr |-> !mem_fwd)
        else $error("forwarded below prefetch base");
    AST_MEM_ABOVE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_addr > pref_hi_addr |-> !mem_fwd)
        else $error("forwarded above prefetch limit");
    AST_MEM_INSIDE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_addr >= pref_lo_addr && mem_addr <= pref_hi_addr |-> mem_fwd)
        else $error("inside prefetch window not forwarded");
    AST_IO_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.io_bot_hi == 16'h0000 &&
                     state.io_top_hi == 16'h0000)
        else $error("io upper fields not reset");
    AST_IO_WR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_wr.valid && cfg_wr.offset == bwc_pkg::OFS_IO_HI &&
        cfg_wr.byte_en == 4'hF && !preload.valid
        |=> state.io_bot_hi == $past(cfg_wr.data[15:0]) &&
            state.io_top_hi == $past(cfg_wr.data[31:16]))
        else $error("io upper fields not written");
    AST_IO_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_IO_HI
        |=> cfg_rd_data == {$past(state.io_top_hi), $past(state.io_bot_hi)})
        else $error("io upper fields read back wrong");
    AST_IO_ABOVE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        io_addr > io_hi_addr |-> !io_fwd)
        else $error("io forwarded above limit");
    AST_IO_BELOW: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        io_addr < io_lo_addr |-> !io_fwd)
        else $error("io forwarded below base");
    AST_IO_INSIDE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        io_addr >= io_lo_addr && io_addr <= io_hi_addr |-> io_fwd)
        else $error("inside io window not forwarded");
    AST_CAP_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.cap_ptr == 8'h40)
        else $error("capability pointer not at default");
    AST_CAP_RO: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !preload.valid |=> state.cap_ptr == $past(state.cap_ptr))
        else $error("capability pointer changed by software");
    AST_CAP_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_CAP
        |=> cfg_rd_data == {24'h000000, $past(state.cap_ptr)})
        else $error("capability pointer read back wrong");
    AST_LINE_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.irq_line == 8'h00)
        else $error("interrupt line not reset");
    AST_LINE_WR: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_wr.valid && cfg_wr.offset == bwc_pkg::OFS_IRQ &&
        cfg_wr.byte_en[0] && !preload.valid
        |=> state.irq_line == $past(cfg_wr.data[7:0]))
        else $error("interrupt line not written");
    AST_IRQ_RD: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        cfg_rd_valid && cfg_rd_offset == bwc_pkg::OFS_IRQ
        |=> cfg_rd_data == {16'h0000, $past(state.irq_pin),
                            $past(state.irq_line)})
        else $error("interrupt dword read back wrong");
    AST_PIN_RESET: assert property (
        @(posedge sys_clk)
        !reset_n |=> state.irq_pin == (IS_DOWNSTREAM ? 8'h01 : 8'h00))
        else $error("interrupt pin wrong for port side");
    AST_PIN_RO: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !preload.valid |=> state.irq_pin == $past(state.irq_pin))
        else $error("interrupt pin changed by software");
    AST_HOTPLUG: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        hotplug_event |=> hotplug_irq == IS_DOWNSTREAM)
        else $error("hot-plug interrupt wrong for port side");
    AST_HOTPLUG_IDLE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        !hotplug_event |=> !hotplug_irq)
        else $error("hot-plug interrupt without event");
    AST_BOT_ZEROS: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        mem_addr == {state.pref_bot_hi, state.pref_bot, 20'h00000} &&
        pref_lo_addr <= pref_hi_addr |-> mem_fwd)
        else $error("window bottom not inclusive");
    AST_BOT_EDGE: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        {state.pref_bot_hi, state.pref_bot} != 44'h000_0000_0000 &&
        mem_addr == {state.pref_bot_hi, state.pref_bot, 20'h00000} - 64'h1
        |-> !mem_fwd)
        else $error("forwarded below window bottom");
    AST_INVERTED: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        pref_lo_addr > pref_hi_addr |-> !mem_fwd)
        else $error("inverted window matched");
    AST_PRE_CAP: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        preload.valid && preload.offset == bwc_pkg::OFS_CAP
        |=> state.cap_ptr == $past(preload.data[7:0]))
        else $error("capability pointer not preloaded");
    AST_PRE_PIN: assert property (
        @(posedge sys_clk) disable iff (!reset_n)
        preload.valid && preload.offset == bwc_pkg::OFS_IRQ
        |=> state.irq_pin == $past(preload.data[15:8]))
        else $error("interrupt pin not preloaded");
endmodule // bwc_window_regs

// >>> common/bwc_pkg.sv
package bwc_pkg;
    localparam logic [7:0] OFS_PREF_DW = 8'h24;
    localparam logic [7:0] OFS_PREF_BOT_HI = 8'h28;
    localparam logic [7:0] OFS_PREF_TOP_HI = 8'h2C;
    localparam logic [7:0] OFS_IO_HI = 8'h30;
    localparam logic [7:0] OFS_CAP = 8'h34;
    localparam logic [7:0] OFS_IRQ = 8'h3C;
    localparam int PREF_CAP_LSB = 16;
    localparam int PREF_TOP_LSB = 20;
    localparam int PREF_BOT_LSB = 4;
    localparam int IO_TOP_LSB = 16;
    localparam int IRQ_PIN_LSB = 8;
    localparam logic [3:0] PREF_64BIT_CODE = 4'h1;
    localparam logic [11:0] RST_PREF_12 = 12'h000;
    localparam logic [31:0] RST_HI32 = 32'h0000_0000;
    localparam logic [15:0] RST_IO16 = 16'h0000;
    localparam logic [7:0] RST_CAP_PTR = 8'h40;
    localparam logic [7:0] RST_IRQ_LINE = 8'h00;
    localparam logic [7:0] IRQ_PIN_UP = 8'h00;
    localparam logic [7:0] IRQ_PIN_DOWN = 8'h01;
    localparam logic [19:0] LOW20_ONES = 20'hFFFFF;
    localparam logic [19:0] LOW20_ZERO = 20'h00000;

    typedef struct packed {
        logic [11:0] pref_bot;
        logic [11:0] pref_top;
        logic [31:0] pref_bot_hi;
        logic [31:0] pref_top_hi;
        logic [15:0] io_bot_hi;
        logic [15:0] io_top_hi;
        logic [7:0] cap_ptr;
        logic [7:0] irq_line;
        logic [7:0] irq_pin;
        logic [31:0] rdata;
        logic hotplug_irq;
    } bwc_state_t;

    typedef struct packed {
        logic valid;
        logic [7:0] offset;
        logic [3:0] byte_en;
        logic [31:0] data;
    } bwc_cfg_wr_t;

    typedef struct packed {
        logic valid;
        logic [7:0] offset;
        logic [31:0] data;
    } bwc_preload_t;
endpackage

// >>> bench/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ps;
`define CHK(got, exp) chk(64'(got), 64'(exp))
    logic sys_clk;
    logic reset_n;
    bwc_pkg::bwc_cfg_wr_t cfg_wr;
    logic cfg_rd_valid;
    logic [7:0] cfg_rd_offset;
    logic [31:0] cfg_rd_data;
    bwc_pkg::bwc_preload_t preload;
    logic [63:0] mem_addr;
    logic [31:0] io_addr;
    logic [11:0] io_base_low;
    logic [11:0] io_limit_low;
    logic hotplug_event;
    logic mem_fwd;
    logic io_fwd;
    logic hotplug_irq;
    int errors;
    int samples_checked;
    int cycles;
    logic [31:0] rd_val;

    bwc_window_regs #(.IS_DOWNSTREAM(1'b1), .IO_LOW_BITS(16))
        bwc_window_regs_inst (
        .sys_clk(sys_clk), .reset_n(reset_n), .cfg_wr(cfg_wr),
        .cfg_rd_valid(cfg_rd_valid), .cfg_rd_offset(cfg_rd_offset),
        .cfg_rd_data(cfg_rd_data), .preload(preload),
        .mem_addr(mem_addr), .io_addr(io_addr),
        .io_base_low(io_base_low), .io_limit_low(io_limit_low),
        .hotplug_event(hotplug_event), .mem_fwd(mem_fwd),
        .io_fwd(io_fwd), .hotplug_irq(hotplug_irq));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [31:0] d,
        input logic [3:0] be);
        @(posedge sys_clk);
        cfg_wr <= '{valid: 1'b1, offset: ofs, byte_en: be, data: d};
        @(posedge sys_clk);
        cfg_wr.valid <= 1'b0;
    endtask

    // The read answer lands on the same edge that takes the request.
    task automatic rd(input logic [7:0] ofs);
        @(posedge sys_clk);
        cfg_rd_valid <= 1'b1;
        cfg_rd_offset <= ofs;
        @(posedge sys_clk);
        cfg_rd_valid <= 1'b0;
        @(negedge sys_clk);
        rd_val = cfg_rd_data;
    endtask

    // Forwarding outputs are combinational, so they are judged mid-cycle.
    task automatic put(input logic [63:0] m, input logic [31:0] i);
        @(posedge sys_clk);
        mem_addr <= m;
        io_addr <= i;
        @(negedge sys_clk);
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic test_reset;
        rd(8'h24);
        `CHK(rd_val, 32'h0001_0001);
        rd(8'h28);
        `CHK(rd_val, 32'h0);
        rd(8'h2C);
        `CHK(rd_val, 32'h0);
        rd(8'h30);
        `CHK(rd_val, 32'h0);
        rd(8'h34);
        `CHK(rd_val, 32'h40);
        rd(8'h3C);
        `CHK(rd_val, 32'h0000_0100);
        $display("test reset values done");
    endtask

    task automatic test_access;
        wr(8'h24, 32'hFFFF_FFFF, 4'hF);
        rd(8'h24);
        `CHK(rd_val, 32'hFFF1_FFF1);
        wr(8'h28, 32'hA5A5_5A5A, 4'hF);
        wr(8'h28, 32'h0000_00C3, 4'h1);
        rd(8'h28);
        `CHK(rd_val, 32'hA5A5_5AC3);
        wr(8'h2C, 32'h1234_5678, 4'hF);
        rd(8'h2C);
        `CHK(rd_val, 32'h1234_5678);
        wr(8'h30, 32'hBEEF_CAFE, 4'hF);
        rd(8'h30);
        `CHK(rd_val, 32'hBEEF_CAFE);
        wr(8'h34, 32'hFFFF_FFFF, 4'hF);
        rd(8'h34);
        `CHK(rd_val, 32'h40);
        wr(8'h3C, 32'h0000_FFFF, 4'hF);
        rd(8'h3C);
        `CHK(rd_val, 32'h0000_01FF);
        wr(8'h50, 32'hFFFF_FFFF, 4'hF);
        rd(8'h50);
        `CHK(rd_val, 32'h0);
        $display("test register access done");
    endtask

    task automatic test_windows;
        wr(8'h24, 32'h1230_1200, 4'hF);
        wr(8'h28, 32'h0000_0001, 4'hF);
        wr(8'h2C, 32'h0000_0001, 4'hF);
        wr(8'h30, 32'h0002_0001, 4'hF);
        io_base_low <= 12'h300;
        io_limit_low <= 12'h500;
        put(64'h1_1200_0000, 32'h0001_3000);
        `CHK(mem_fwd, 1'b1);
        `CHK(io_fwd, 1'b1);
        put(64'h1_123F_FFFF, 32'h0002_5FFF);
        `CHK(mem_fwd, 1'b1);
        `CHK(io_fwd, 1'b1);
        put(64'h1_1240_0000, 32'h0002_6000);
        `CHK(mem_fwd, 1'b0);
        `CHK(io_fwd, 1'b0);
        put(64'h1_11FF_FFFF, 32'h0001_2FFF);
        `CHK(mem_fwd, 1'b0);
        `CHK(io_fwd, 1'b0);
        put(64'h0_1200_0000, 32'h0001_3000);
        `CHK(mem_fwd, 1'b0);
        wr(8'h24, 32'h1200_1230, 4'hF);
        put(64'h1_1220_0000, 32'h0);
        `CHK(mem_fwd, 1'b0);
        $display("test windows done");
    endtask

    task automatic test_hotplug_preload;
        @(posedge sys_clk);
        hotplug_event <= 1'b1;
        @(posedge sys_clk);
        hotplug_event <= 1'b0;
        @(negedge sys_clk);
        `CHK(hotplug_irq, 1'b1);
        @(posedge sys_clk);
        @(negedge sys_clk);
        `CHK(hotplug_irq, 1'b0);
        @(posedge sys_clk);
        preload <= '{valid: 1'b1, offset: 8'h34, data: 32'h0000_0050};
        @(posedge sys_clk);
        preload <= '{valid: 1'b1, offset: 8'h3C, data: 32'h0000_0200};
        cfg_wr <= '{valid: 1'b1, offset: 8'h3C, byte_en: 4'h1,
                    data: 32'h0000_0077};
        @(posedge sys_clk);
        preload.valid <= 1'b0;
        cfg_wr.valid <= 1'b0;
        rd(8'h34);
        `CHK(rd_val, 32'h50);
        rd(8'h3C);
        `CHK(rd_val, 32'h0000_0277);
        $display("test hot-plug and preload done");
    endtask

    // A second reset in mid-run must bring back the prefetch top high, capability pointer and interrupt dword defaults.
    task automatic test_mid_reset;
        @(posedge sys_clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(8'h2C);
        `CHK(rd_val, 32'h0);
        rd(8'h34);
        `CHK(rd_val, 32'h40);
        rd(8'h3C);
        `CHK(rd_val, 32'h0000_0100);
        $display("test mid-run reset done");
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            report_and_stop();
        end
    end

    initial begin
        errors = 0;
        samples_checked = 0;
        cycles = 0;
        reset_n = 1'b0;
        cfg_wr = '0;
        cfg_rd_valid = 1'b0;
        cfg_rd_offset = 8'h00;
        preload = '0;
        mem_addr = 64'h0;
        io_addr = 32'h0;
        io_base_low = 12'h000;
        io_limit_low = 12'h000;
        hotplug_event = 1'b0;
        repeat (3) @(posedge sys_clk);
        reset_n <= 1'b1;
        test_reset();
        test_access();
        test_windows();
        test_hotplug_preload();
        test_mid_reset();
        report_and_stop();
    end
endmodule // tb
